// file: design/tsx_pkg.sv
package tsx_pkg;

  // ==========================================================================
  // Register map (byte offsets on the APB side)
  localparam logic [7:0] REG_INSTR  = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_BANK   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TPTR   = 8'h10;
  localparam logic [7:0] REG_TLAT   = 8'h14;
  localparam logic [7:0] REG_CYCLES = 8'h18;
  localparam logic [7:0] REG_FADDR  = 8'h1c;
  localparam logic [7:0] REG_FDATA  = 8'h20;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [20:0] TPTR_RST  = 21'h000000;
  localparam logic [7:0]  TLAT_RST  = 8'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // ==========================================================================
  // Status register bit positions
  localparam int ST_Z_BIT    = 0;
  localparam int ST_N_BIT    = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_SKIP_BIT = 3;

  // ==========================================================================
  // Opcode patterns and addressing constants
  localparam logic [6:0]  OPC_TST    = 7'h33;     // instr[15:9]
  localparam logic [7:0]  OPC_XOR_LIT = 8'h0a;    // instr[15:8]
  localparam logic [5:0]  OPC_XOR_REG = 6'h06;    // instr[15:10]
  localparam logic [13:0] OPC_TAB_WR  = 14'h0003; // instr[15:2]
  localparam logic [3:0]  OPC_MOVE2  = 4'hc;      // two-word move, instr[15:12]
  localparam logic [5:0]  OPC_LONG2  = 6'h3b;     // two-word branch group, instr[15:10]
  localparam logic [3:0]  ACCESS_LO  = 4'h0;
  localparam logic [3:0]  ACCESS_HI  = 4'hf;
  localparam logic [1:0]  TM_NONE    = 2'h0;
  localparam logic [1:0]  TM_POSTINC = 2'h1;
  localparam logic [1:0]  TM_POSTDEC = 2'h2;
  localparam logic [1:0]  TM_PREINC  = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } tsx_phase_t;

  typedef enum logic [2:0] {
    K_NOP     = 3'b000,
    K_TST     = 3'b001,
    K_XOR_LIT = 3'b010,
    K_XOR_REG = 3'b011,
    K_TAB_WR  = 3'b100
  } tsx_kind_t;

  typedef enum logic [1:0] {
    SK_NONE   = 2'b00,
    SK_FIRST  = 2'b01,
    SK_SECOND = 2'b10
  } tsx_skip_t;

  typedef struct packed {
    tsx_kind_t  kind;
    logic       dest;
    logic       acc_sel;
    logic [7:0] faddr;
    logic [7:0] lit;
    logic [1:0] tmode;
  } tsx_dec_t;

  // Split an instruction word into its fields
  function automatic tsx_dec_t tsx_decode(input logic [15:0] w);
    tsx_dec_t d;
    d.kind    = K_NOP;
    d.dest    = w[9];
    d.acc_sel = w[8];
    d.faddr   = w[7:0];
    d.lit     = w[7:0];
    d.tmode   = w[1:0];
    if (w[15:9] == OPC_TST) begin
      d.kind = K_TST;
    end else if (w[15:8] == OPC_XOR_LIT) begin
      d.kind = K_XOR_LIT;
    end else if (w[15:10] == OPC_XOR_REG) begin
      d.kind = K_XOR_REG;
    end else if (w[15:2] == OPC_TAB_WR) begin
      d.kind = K_TAB_WR;
    end
    return d;
  endfunction : tsx_decode

  // Instructions that occupy two program words
  function automatic logic tsx_two_word(input logic [15:0] w);
    return (w[15:12] == OPC_MOVE2) || (w[15:10] == OPC_LONG2);
  endfunction : tsx_two_word

endpackage : tsx_pkg

// file: design/tsx_mem.sv
`timescale 1ns/1ps
// ============================================================================
// File register RAM with registered read data
module tsx_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read is registered so the address must be held one cycle ahead
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : tsx_mem

// file: design/tsx_core.sv
`timescale 1ns/1ps
// How it works
// [RL1] Opcode 0110 011a plus 8-bit address tests a register; zero skips next.
// [RL2] A skip turns the fetched next instruction into a no-operation cycle.
// [RL3] A skipped two-word instruction costs two no-operation cycles, three in total.
// [RL4] Access-select 0 uses the access bank and ignores the bank select value.
// [RL5] Access-select 1 forms the address from the bank select value.
// [RL6] XOR literal: accumulator xor 8-bit literal back into the accumulator.
// [RL7] XOR literal is recognised by upper byte 0000 1010.
// [RL8] XOR register: accumulator xor addressed file register.
// [RL9] XOR register is recognised by prefix 0001 10, then d, a, address.
// [RL10] Destination bit 0 writes the accumulator, file register untouched.
// [RL11] Destination bit 1 writes the file register, accumulator untouched.
// [RL12] Post-increment table write stores at pointer, then pointer plus one.
// [RL13] Pre-increment table write advances pointer first, then stores there.
// [RL14] Pointer mode: 0 none, 1 post-inc, 2 post-dec, 3 pre-inc.
// [RL15] XORs set N from bit 7 and Z on zero; the test keeps flags.
// [RL16] XORs take one cycle: decode, read, process, write in four quarters.
module tsx_core
  import tsx_pkg::*;
#(
  parameter int PTR_W = 21,
  parameter int FA_W  = 12
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic      [PTR_W-1:0] tw_addr,
  output logic      [7:0]       tw_data,
  output logic                  tw_stb
);

  // ==========================================================================
  // State
  tsx_phase_t       phase_reg,  phase_next;
  tsx_dec_t         dec_reg,    dec_next;
  tsx_skip_t        skip_reg,   skip_next;
  logic [15:0]      instr_reg,  instr_next;
  logic [7:0]       acc_reg,    acc_next;
  logic [3:0]       bank_reg,   bank_next;
  logic [PTR_W-1:0] tptr_reg,   tptr_next;
  logic [7:0]       tlat_reg,   tlat_next;
  logic             zf_reg,     zf_next;
  logic             nf_reg,     nf_next;
  logic [15:0]      cyc_reg,    cyc_next;
  logic [FA_W-1:0]  faddr_reg,  faddr_next;
  logic [7:0]       res_reg,    res_next;
  logic [PTR_W-1:0] twa_reg,    twa_next;
  logic [7:0]       twd_reg,    twd_next;
  logic             stb_reg,    stb_next;
  logic [31:0]      rdat_reg,   rdat_next;
  logic             rdone_reg,  rdone_next;
  logic             idle_q_reg, idle_q_next;

  logic             busy, acc_ph, wr_ok, rd_ok, mapped;
  logic [FA_W-1:0]  ea, mem_addr;
  logic             mem_we;
  logic [7:0]       mem_wdata, mem_rdata;
  logic [31:0]      rd_val;

  // One clock and one reset for every check in this module
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Effective file address and memory port sharing
  assign busy   = (phase_reg != PH_IDLE);
  always_comb begin
    if (dec_reg.acc_sel) begin
      ea = FA_W'({bank_reg, dec_reg.faddr});                          // RL5
    end else begin
      ea = FA_W'({dec_reg.faddr[7] ? ACCESS_HI : ACCESS_LO, dec_reg.faddr}); // RL4
    end
  end
  // Core owns the RAM while busy; software window otherwise
  assign mem_addr  = busy ? ea : faddr_reg;
  assign mem_we    = (phase_reg == PH_Q4 && dec_reg.kind == K_XOR_REG && dec_reg.dest) // RL11
                   || (wr_ok && paddr == REG_FDATA);
  assign mem_wdata = busy ? res_reg : pwdata[7:0];

  tsx_mem #(.AW(FA_W), .DW(8)) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // ==========================================================================
  // APB decode; writes wait while an instruction runs
  assign acc_ph = psel && penable;
  assign wr_ok  = acc_ph && pwrite && !busy;
  // Window read needs one idle cycle so the RAM output matches faddr
  assign rd_ok  = acc_ph && !pwrite && !rdone_reg
                && !(paddr == REG_FDATA && !(idle_q_reg && !busy));
  assign pready  = acc_ph && (pwrite ? !busy : rdone_reg);
  assign pslverr = pready && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      REG_INSTR:  rd_val = {16'h0, instr_reg};
      REG_ACC:    rd_val = {24'h0, acc_reg};
      REG_BANK:   rd_val = {28'h0, bank_reg};
      REG_STATUS: begin
        rd_val[ST_Z_BIT]    = zf_reg;
        rd_val[ST_N_BIT]    = nf_reg;
        rd_val[ST_BUSY_BIT] = busy;
        rd_val[ST_SKIP_BIT] = (skip_reg != SK_NONE);
      end
      REG_TPTR:   rd_val = 32'(tptr_reg);
      REG_TLAT:   rd_val = {24'h0, tlat_reg};
      REG_CYCLES: rd_val = {16'h0, cyc_reg};
      REG_FADDR:  rd_val = 32'(faddr_reg);
      REG_FDATA:  rd_val = {24'h0, mem_rdata};
      default:    mapped = 1'b0;
    endcase
  end

  // Read data captured one cycle into the access phase
  always_comb begin
    rdat_next   = rdat_reg;
    rdone_next  = 1'b0;
    idle_q_next = !busy;
    if (rd_ok) begin
      rdat_next  = rd_val;
      rdone_next = 1'b1;
    end
  end

  // ==========================================================================
  // Execution sequencer and software writes
  always_comb begin
    phase_next = phase_reg;
    dec_next   = dec_reg;
    skip_next  = skip_reg;
    instr_next = instr_reg;
    acc_next   = acc_reg;
    bank_next  = bank_reg;
    tptr_next  = tptr_reg;
    tlat_next  = tlat_reg;
    zf_next    = zf_reg;
    nf_next    = nf_reg;
    cyc_next   = cyc_reg;
    faddr_next = faddr_reg;
    res_next   = res_reg;
    twa_next   = twa_reg;
    twd_next   = twd_reg;
    stb_next   = 1'b0;
    case (phase_reg)
      PH_IDLE: begin
        if (wr_ok) begin
          case (paddr)
            REG_INSTR: begin
              instr_next = pwdata[15:0];
              phase_next = PH_Q1;
            end
            REG_ACC:   acc_next   = pwdata[7:0];
            REG_BANK:  bank_next  = pwdata[3:0];
            REG_TPTR:  tptr_next  = pwdata[PTR_W-1:0];
            REG_TLAT:  tlat_next  = pwdata[7:0];
            REG_FADDR: faddr_next = pwdata[FA_W-1:0];
            default:   ;
          endcase
        end
      end
      PH_Q1: begin
        // Decode; a pending skip replaces the word with a no-operation
        dec_next = tsx_decode(instr_reg);                             // RL7 RL9
        case (skip_reg)
          SK_FIRST: begin
            dec_next.kind = K_NOP;                                    // RL2
            skip_next = tsx_two_word(instr_reg) ? SK_SECOND : SK_NONE; // RL3
          end
          SK_SECOND: begin
            dec_next.kind = K_NOP;                                    // RL3
            skip_next = SK_NONE;
          end
          default: ;
        endcase
        phase_next = PH_Q2;
      end
      PH_Q2: phase_next = PH_Q3;                                      // RL16
      PH_Q3: begin
        case (dec_reg.kind)
          K_XOR_LIT: res_next = acc_reg ^ dec_reg.lit;                // RL6
          K_XOR_REG: res_next = acc_reg ^ mem_rdata;                  // RL8
          default: res_next = mem_rdata;
        endcase
        phase_next = PH_Q4;
      end
      PH_Q4: begin
        case (dec_reg.kind)
          K_TST: begin
            if (res_reg == 8'h00) begin
              skip_next = SK_FIRST;                                   // RL1
            end
          end
          K_XOR_LIT, K_XOR_REG: begin
            if (dec_reg.kind == K_XOR_LIT || !dec_reg.dest) begin
              acc_next = res_reg;                                     // RL6 RL10
            end
            nf_next = res_reg[7];                                     // RL15
            zf_next = (res_reg == 8'h00);                             // RL15
          end
          K_TAB_WR: begin
            twd_next = tlat_reg;
            stb_next = 1'b1;
            twa_next = tptr_reg;
            case (dec_reg.tmode)                                      // RL14
              TM_POSTINC: tptr_next = tptr_reg + 1'b1;                // RL12
              TM_POSTDEC: tptr_next = tptr_reg - 1'b1;
              TM_PREINC: begin
                tptr_next = tptr_reg + 1'b1;                          // RL13
                twa_next  = tptr_reg + 1'b1;
              end
              default: ;
            endcase
          end
          default: ;
        endcase
        cyc_next   = cyc_reg + 1'b1;
        phase_next = PH_IDLE;
      end
      default: phase_next = PH_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg  <= PH_IDLE;
      dec_reg    <= '0;
      skip_reg   <= SK_NONE;
      instr_reg  <= INSTR_RST;
      acc_reg    <= ACC_RST;
      bank_reg   <= BANK_RST;
      tptr_reg   <= TPTR_RST[PTR_W-1:0];
      tlat_reg   <= TLAT_RST;
      zf_reg     <= 1'b0;
      nf_reg     <= 1'b0;
      cyc_reg    <= 16'h0000;
      faddr_reg  <= '0;
      res_reg    <= 8'h00;
      twa_reg    <= '0;
      twd_reg    <= 8'h00;
      stb_reg    <= 1'b0;
      rdat_reg   <= 32'h0;
      rdone_reg  <= 1'b0;
      idle_q_reg <= 1'b0;
    end else begin
      phase_reg  <= phase_next;
      dec_reg    <= dec_next;
      skip_reg   <= skip_next;
      instr_reg  <= instr_next;
      acc_reg    <= acc_next;
      bank_reg   <= bank_next;
      tptr_reg   <= tptr_next;
      tlat_reg   <= tlat_next;
      zf_reg     <= zf_next;
      nf_reg     <= nf_next;
      cyc_reg    <= cyc_next;
      faddr_reg  <= faddr_next;
      res_reg    <= res_next;
      twa_reg    <= twa_next;
      twd_reg    <= twd_next;
      stb_reg    <= stb_next;
      rdat_reg   <= rdat_next;
      rdone_reg  <= rdone_next;
      idle_q_reg <= idle_q_next;
    end
  end

  assign prdata  = rdat_reg;
  assign tw_addr = twa_reg;
  assign tw_data = twd_reg;
  assign tw_stb  = stb_reg;

  // ==========================================================================
  // Assertions
  sequence s_q4(tsx_kind_t k);
    phase_reg == PH_Q4 && dec_reg.kind == k;
  endsequence

  a_skip_on_zero: assert property (s_q4(K_TST) ##0 res_reg == 8'h00 |=> skip_reg == SK_FIRST) // RL1
    else $error("zero test did not arm a skip");
  a_skip_nop: assert property (phase_reg == PH_Q1 && skip_reg != SK_NONE
      |=> dec_reg.kind == K_NOP ##3 acc_reg == $past(acc_reg, 4)) // RL2
    else $error("skipped word was executed");
  a_skip_two_word: assert property (phase_reg == PH_Q1 && skip_reg == SK_FIRST
      && tsx_two_word(instr_reg) |=> skip_reg == SK_SECOND) // RL3
    else $error("second word of skipped instruction not consumed");
  a_access_bank: assert property (phase_reg == PH_Q2 && !dec_reg.acc_sel
      |-> mem_addr[11:8] == (dec_reg.faddr[7] ? ACCESS_HI : ACCESS_LO)) // RL4
    else $error("access bank not forced");
  a_bank_select: assert property (phase_reg == PH_Q2 && dec_reg.acc_sel
      |-> mem_addr[11:8] == bank_reg) // RL5
    else $error("bank select value not used");
  a_xor_literal: assert property (s_q4(K_XOR_LIT)
      |=> acc_reg == ($past(acc_reg) ^ $past(dec_reg.lit)) && zf_reg == (acc_reg == 8'h00)) // RL6
    else $error("literal xor result wrong");
  a_xor_to_acc: assert property (s_q4(K_XOR_REG) ##0 !dec_reg.dest
      |-> !mem_we ##1 acc_reg == $past(res_reg) && nf_reg == acc_reg[7]) // RL10
    else $error("xor to accumulator wrong");
  a_xor_to_file: assert property (s_q4(K_XOR_REG) ##0 dec_reg.dest
      |-> mem_we && mem_wdata == res_reg ##1 acc_reg == $past(acc_reg)) // RL11
    else $error("xor to file register wrong");
  a_table_post: assert property (s_q4(K_TAB_WR) ##0 dec_reg.tmode == TM_POSTINC
      |=> tw_stb && tw_addr == $past(tptr_reg) && tptr_reg == tw_addr + 1'b1) // RL12
    else $error("post-increment table write wrong");
  a_table_pre: assert property (s_q4(K_TAB_WR) ##0 dec_reg.tmode == TM_PREINC
      |=> tw_stb && tw_addr == tptr_reg && tptr_reg == $past(tptr_reg) + 1'b1) // RL13
    else $error("pre-increment table write wrong");
  a_table_dec: assert property (s_q4(K_TAB_WR) ##0 dec_reg.tmode == TM_POSTDEC
      |=> tptr_reg == $past(tptr_reg) - 1'b1 && tw_data == tlat_reg) // RL14
    else $error("post-decrement table write wrong");
  a_test_flags: assert property (s_q4(K_TST) |=> $stable(zf_reg) && $stable(nf_reg)) // RL15
    else $error("zero test changed flags");
  a_four_quarters: assert property (phase_reg == PH_Q1 |=> phase_reg == PH_Q2
      ##1 phase_reg == PH_Q3 ##1 phase_reg == PH_Q4 ##1 phase_reg == PH_IDLE) // RL16
    else $error("instruction cycle not four quarters");

endmodule : tsx_core

// file: verification/test_skip_xor_table_write_exec_bench.sv
`timescale 1ns/1ps
module test_skip_xor_table_write_exec_bench
  import tsx_pkg::*;
();

  // ==========================================================================
  // Signals and tables
  logic        clk = 1'b0;
  logic        rst, psel, penable, pwrite, pready, pslverr, tw_stb;
  logic [7:0]  paddr, tw_data, stb_data;
  logic [31:0] pwdata, prdata, v;
  logic [20:0] tw_addr, stb_addr;
  logic        e;
  int          bad_count = 0;
  int          check_count = 0;
  int          stb_count = 0;
  int          n0;

  typedef struct packed {
    logic [15:0] w;
    logic [7:0]  acc0;
    logic [3:0]  bank;
    logic [11:0] fa;
    logic [7:0]  mem0;
    logic [7:0]  acc1;
    logic [7:0]  mem1;
    logic [1:0]  nz;
  } tsx_row_t;

  // Bank 5/7 on access-bank rows proves the bank value is ignored there
  tsx_row_t rows[5] = '{
    '{16'h0aaf, 8'hb5, 4'h0, 12'h005, 8'h3c, 8'h1a, 8'h3c, 2'b00},
    '{16'h0a80, 8'h80, 4'h0, 12'h005, 8'h3c, 8'h00, 8'h3c, 2'b01},
    '{16'h1a10, 8'hb5, 4'h5, 12'h010, 8'haf, 8'hb5, 8'h1a, 2'b00},
    '{16'h1922, 8'h0f, 4'h3, 12'h322, 8'hf0, 8'hff, 8'hf0, 2'b10},
    '{16'h1a90, 8'h55, 4'h7, 12'hf90, 8'h55, 8'h55, 8'h00, 2'b01}};
  // Pointer modes 0..3: start pointer, strobe address, final pointer, latch
  logic [20:0] tp0[4] = '{21'h000100, 21'h00a356, 21'h000000, 21'h01389a};
  logic [20:0] tpa[4] = '{21'h000100, 21'h00a356, 21'h000000, 21'h01389b};
  logic [20:0] tp1[4] = '{21'h000100, 21'h00a357, 21'h1fffff, 21'h01389b};
  logic [7:0]  tlv[4] = '{8'h11, 8'h55, 8'h22, 8'h34};
  logic [7:0]  rz[7]  = '{REG_INSTR, REG_ACC, REG_BANK, REG_STATUS, REG_TPTR,
                          REG_TLAT, REG_CYCLES};

  tsx_core #(.PTR_W(21), .FA_W(12)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tw_addr(tw_addr), .tw_data(tw_data), .tw_stb(tw_stb));

  // ==========================================================================
  // Clock and table-write strobe monitor (strobe lasts one cycle only)
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (tw_stb === 1'b1) begin
      stb_count <= stb_count + 1;
      stb_addr  <= tw_addr;
      stb_data  <= tw_data;
    end
  end

  // ==========================================================================
  // Tasks
  task summarize;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pready is taken right at the rising edge, before the design's registers
  // move, so it is exactly the value that edge samples
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic er);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 64) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, v, e);
    chk(v, exp);
  endtask : rdchk

  // Start one instruction and poll busy under a bound
  task exec(input logic [15:0] w);
    int k;
    wr(REG_INSTR, 32'(w));
    for (k = 0; k < 20; k++) begin
      apb(1'b0, REG_STATUS, 32'h0, v, e);
      if (v[ST_BUSY_BIT] === 1'b0) break;
    end
    if (k == 20) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask : exec

  // ==========================================================================
  // Main sequence
  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then an unmapped place
    foreach (rz[i]) rdchk(rz[i], 32'h0);
    apb(1'b1, 8'h40, 32'hff, v, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h40, 32'h0, v, e);
    chk(32'(e), 32'h1);
    chk(v, 32'h0);
    // XOR cases from the table
    foreach (rows[i]) begin
      wr(REG_ACC, 32'(rows[i].acc0));
      wr(REG_BANK, 32'(rows[i].bank));
      wr(REG_FADDR, 32'(rows[i].fa));
      wr(REG_FDATA, 32'(rows[i].mem0));
      exec(rows[i].w);
      rdchk(REG_ACC, 32'(rows[i].acc1));
      rdchk(REG_FDATA, 32'(rows[i].mem1));
      rdchk(REG_STATUS, 32'(rows[i].nz));
    end
    rdchk(REG_CYCLES, 32'h5);
    // Zero test skips a one-word instruction; flags untouched
    wr(REG_FADDR, 32'h010);
    wr(REG_FDATA, 32'h0);
    exec(16'h6610);
    exec(16'h0aff);
    rdchk(REG_ACC, 32'h55);
    rdchk(REG_STATUS, 32'h1);
    rdchk(REG_CYCLES, 32'h7);
    // Non-zero register: the next instruction runs
    wr(REG_FDATA, 32'h1);
    exec(16'h6610);
    rdchk(REG_STATUS, 32'h1);
    exec(16'h0a0f);
    rdchk(REG_ACC, 32'h5a);
    // Skip over a two-word instruction costs two discarded cycles
    wr(REG_FDATA, 32'h0);
    exec(16'h6610);
    exec(16'hc000);
    exec(16'h0aff);
    rdchk(REG_ACC, 32'h5a);
    rdchk(REG_CYCLES, 32'hc);
    exec(16'h0a5a);
    rdchk(REG_ACC, 32'h0);
    // Skip over the other two-word group; skip pending shows in status
    exec(16'h6610);
    rdchk(REG_STATUS, 32'h9);
    exec(16'hec00);
    exec(16'h0aff);
    rdchk(REG_ACC, 32'h0);
    // Table write in every pointer mode, including the post-decrement wrap from zero
    for (int m = 0; m < 4; m++) begin
      wr(REG_TPTR, 32'(tp0[m]));
      wr(REG_TLAT, 32'(tlv[m]));
      n0 = stb_count;
      exec(16'h000c + 16'(m));
      chk(32'(stb_count - n0), 32'h1);
      chk(32'(stb_addr), 32'(tpa[m]));
      chk(32'(stb_data), 32'(tlv[m]));
      rdchk(REG_TPTR, 32'(tp1[m]));
    end
    // Second reset in mid-run, while an instruction is still in its quarters
    wr(REG_ACC, 32'h77);
    wr(REG_INSTR, 32'h0a01);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(REG_ACC, 32'h0);
    rdchk(REG_STATUS, 32'h0);
    rdchk(REG_TPTR, 32'h0);
    summarize();
  end
endmodule : test_skip_xor_table_write_exec_bench
